// file: bnv_map.svh
// register indices, field positions, reset values and boost limits
`ifndef BNV_MAP_SVH
`define BNV_MAP_SVH
`define BNV_IDX_BOOST_SYNC 8'hA5
`define BNV_IDX_DIV_HIGH 8'hA6
`define BNV_IDX_DIV_LOW 8'hA7
`define BNV_IDX_CTRL 8'hA8
`define BNV_IDX_STATUS 8'hA9
`define BNV_RST_BOOST_SYNC 8'h00
`define BNV_RST_DIV_HIGH 8'h00
`define BNV_RST_DIV_LOW 8'h00
`define BNV_RST_CTRL 8'h00
`define BNV_BIT_SYNC_EN 7
`define BNV_BIT_RATE_RES 2
`define BNV_BIT_ADAPT_EN 5
`define BNV_BOOST_MIN_V 6'h0A
`define BNV_BOOST_MAX_V 6'h28
`define BNV_HYST_W11 13'h0004
`define BNV_HYST_W10 13'h0008
`define BNV_HYST_W8 13'h0020
`endif

// file: bnv_pkg.sv
// types shared by the backlight configuration block
package bnv_pkg;
	typedef struct packed {
		logic syncEn;
		logic [1:0] ditherDepth;
		logic [4:0] boostVoltageCode;
	} bnv_boost_sync_t;
	typedef struct packed {
		logic [4:0] divLow;
		logic rateResistorEnable;
		logic [1:0] hystCode;
	} bnv_div_low_t;
	typedef struct packed {
		logic [1:0] spare;
		logic adaptEn;
		logic [4:0] outputRateCode;
	} bnv_ctrl_t;
	typedef enum logic [1:0] {
		BNV_HYST_OFF,
		BNV_HYST_11B,
		BNV_HYST_10B,
		BNV_HYST_8B
	} bnv_hyst_t;
endpackage : bnv_pkg

// file: bnv_boost_target.sv
// boost voltage target: fixed from code or adaptive from code start point
`include "bnv_map.svh"
module bnv_boost_target (
	input wire logic clk,
	input wire logic srst,
	input wire logic [4:0] boostVoltageCode,
	input wire logic codeLoad,
	input wire logic adaptEn,
	input wire logic stepUp,
	input wire logic stepDown,
	output logic [5:0] targetVolts
);
	logic [5:0] targetVolts_ff;
	logic adaptEn_ff;

	function automatic logic [5:0] codeToVolts(input logic [4:0] code);
		logic [5:0] v;
		v = {1'b0, code} + `BNV_BOOST_MIN_V;
		if (v > `BNV_BOOST_MAX_V) begin
			v = `BNV_BOOST_MAX_V;
		end
		return v;
	endfunction : codeToVolts

	always_ff @(posedge clk) begin
		if (srst) begin
			adaptEn_ff <= 1'b0;
		end else begin
			adaptEn_ff <= adaptEn;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			targetVolts_ff <= `BNV_BOOST_MIN_V;
		end else if (!adaptEn) begin
			targetVolts_ff <= codeToVolts(boostVoltageCode);
		end else if (!adaptEn_ff || codeLoad) begin
			targetVolts_ff <= codeToVolts(boostVoltageCode);
		end else if (stepUp && !stepDown && targetVolts_ff < `BNV_BOOST_MAX_V) begin
			targetVolts_ff <= targetVolts_ff + 6'h01;
		end else if (stepDown && !stepUp && targetVolts_ff > `BNV_BOOST_MIN_V) begin
			targetVolts_ff <= targetVolts_ff - 6'h01;
		end
	end

	assign targetVolts = targetVolts_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	a_boost_fixed: assert property (!adaptEn |=> targetVolts == codeToVolts($past(boostVoltageCode)))
		else $error("fixed boost target does not follow code");
	a_boost_range: assert property (##1 (targetVolts >= 6'h0A && targetVolts <= 6'h28))
		else $error("boost target outside 10..40 V");
	a_boost_start: assert property (adaptEn && !adaptEn_ff |=> targetVolts == codeToVolts($past(boostVoltageCode)))
		else $error("adaptive start point not taken from code");
	a_boost_step: assert property (adaptEn && adaptEn_ff && !codeLoad && stepUp && !stepDown
		&& targetVolts < 6'h28 |=> targetVolts == $past(targetVolts) + 6'h01)
		else $error("adaptive step up missed");
endmodule : bnv_boost_target

// file: bnv_hyst_filter.sv
// input duty hysteresis filter
`include "bnv_map.svh"
module bnv_hyst_filter (
	input wire logic clk,
	input wire logic srst,
	input wire logic [12:0] dutyIn,
	input wire logic dutyInValid,
	input wire logic [1:0] hystCode,
	output logic [12:0] dutyOut,
	output logic dutyOutValid
);
	logic [12:0] dutyOut_ff;
	logic dutyOutValid_ff;
	logic [12:0] diff;
	logic accept;

	function automatic logic [12:0] hystWeight(input logic [1:0] code);
		case (bnv_pkg::bnv_hyst_t'(code))
			bnv_pkg::BNV_HYST_11B: hystWeight = `BNV_HYST_W11;
			bnv_pkg::BNV_HYST_10B: hystWeight = `BNV_HYST_W10;
			bnv_pkg::BNV_HYST_8B: hystWeight = `BNV_HYST_W8;
			default: hystWeight = 13'h0000;
		endcase
	endfunction : hystWeight

	always_comb begin
		diff = (dutyIn > dutyOut_ff) ? dutyIn - dutyOut_ff : dutyOut_ff - dutyIn;
		accept = (hystCode == 2'h0) || (diff > hystWeight(hystCode));
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			dutyOut_ff <= 13'h0000;
		end else if (dutyInValid && accept) begin
			dutyOut_ff <= dutyIn;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			dutyOutValid_ff <= 1'b0;
		end else begin
			dutyOutValid_ff <= dutyInValid && accept;
		end
	end

	assign dutyOut = dutyOut_ff;
	assign dutyOutValid = dutyOutValid_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	a_hyst_off: assert property (hystCode == 2'h0 && dutyInValid |=> dutyOut == $past(dutyIn))
		else $error("duty not passed with hysteresis off");
	a_hyst_hold: assert property (hystCode == 2'h3 && dutyInValid && diff <= 13'h0020 |=> $stable(dutyOut))
		else $error("small change not ignored at 8-bit resolution");
	a_hyst_take11: assert property (hystCode == 2'h1 && dutyInValid && diff > 13'h0004
		|=> dutyOut == $past(dutyIn) && dutyOutValid)
		else $error("large change ignored at 11-bit resolution");
endmodule : bnv_hyst_filter

// file: bnv_config_regs.sv
// backlight nonvolatile configuration registers with apb access and field decode
// Notes on behaviour
// - sync enable bit clear ignores frame sync; set lets pll take timing from it.
// - dither depth 00 is off; 01, 10, 11 add 1, 2, 3 dither bits.
// - boost code gives 10 V plus 1 V per step, capped at 40 V.
// - adaptive boost on: code is only the start target, then adjusted adaptively.
// - adaptive boost off: code sets the boost target directly and continuously.
// - second register holds pll counter bits 12 to 5.
// - third register bits 7 to 3 hold pll counter bits 4 to 0.
// - assembled pll counter applies only while sync enable is set.
// - rate resistor enable clear uses rate code; set uses external rate resistor.
// - hysteresis field ignores small input duty changes; 00 turns it off.
// - codes 01, 10, 11 give 1-bit hysteresis at 11, 10, 8 bit resolution.
//
// Local design decision: the APB interface to the registers.
`include "bnv_map.svh"
module bnv_config_regs (
	input wire logic clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic frameSyncPin,
	input wire logic headroomLowPin,
	input wire logic headroomHighPin,
	input wire logic [12:0] dutyIn,
	input wire logic dutyInValid,
	output logic syncEnabled,
	output logic pllRefPulse,
	output logic [12:0] pllCount,
	output logic [1:0] ditherBits,
	output logic [5:0] boostTargetVolts,
	output logic boostAdaptive,
	output logic rateFromResistor,
	output logic [4:0] outputRateCode,
	output logic [12:0] dutyOut,
	output logic dutyOutValid
);
	bnv_pkg::bnv_boost_sync_t boostSync_ff;
	logic [7:0] divHigh_ff;
	bnv_pkg::bnv_div_low_t divLow_ff;
	bnv_pkg::bnv_ctrl_t ctrl_ff;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic syncEnabled_ff;
	logic pllRefPulse_ff;
	logic [12:0] pllCount_ff;
	logic [1:0] ditherBits_ff;
	logic rateFromResistor_ff;
	logic [4:0] outputRateCode_ff;
	logic boostAdaptive_ff;
	logic codeLoad_ff;
	logic [2:0] frameSync_ff;
	logic [1:0] headLow_ff;
	logic [1:0] headHigh_ff;
	logic apbSetup;
	logic apbDone;
	logic wrLane0;
	logic [12:0] pllAssembled;

	function automatic logic regHit(input logic [11:0] addr, input logic [7:0] idx);
		return addr == {2'b00, idx, 2'b00};
	endfunction : regHit

	function automatic logic mapped(input logic [11:0] addr);
		return regHit(addr, `BNV_IDX_BOOST_SYNC) || regHit(addr, `BNV_IDX_DIV_HIGH)
			|| regHit(addr, `BNV_IDX_DIV_LOW) || regHit(addr, `BNV_IDX_CTRL)
			|| regHit(addr, `BNV_IDX_STATUS);
	endfunction : mapped

	// apb: one wait state, completion when pready is high
	assign apbSetup = psel && penable && !pready_ff;
	assign apbDone = psel && penable && pready_ff;
	assign wrLane0 = apbDone && pwrite && pstrb[0];
	assign pllAssembled = {divHigh_ff, divLow_ff.divLow};

	always_ff @(posedge clk) begin
		if (srst) begin
			pready_ff <= 1'b0;
		end else begin
			pready_ff <= apbSetup;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			pslverr_ff <= 1'b0;
		end else if (apbSetup) begin
			pslverr_ff <= !mapped(paddr);
		end else begin
			pslverr_ff <= 1'b0;
		end
	end

	// read data, captured with pready
	always_ff @(posedge clk) begin
		if (srst) begin
			prdata_ff <= 32'h00000000;
		end else if (apbSetup && !pwrite) begin
			if (regHit(paddr, `BNV_IDX_BOOST_SYNC)) begin
				prdata_ff <= {24'h000000, boostSync_ff};
			end else if (regHit(paddr, `BNV_IDX_DIV_HIGH)) begin
				prdata_ff <= {24'h000000, divHigh_ff};
			end else if (regHit(paddr, `BNV_IDX_DIV_LOW)) begin
				prdata_ff <= {24'h000000, divLow_ff};
			end else if (regHit(paddr, `BNV_IDX_CTRL)) begin
				prdata_ff <= {24'h000000, ctrl_ff};
			end else if (regHit(paddr, `BNV_IDX_STATUS)) begin
				prdata_ff <= {24'h000000, syncEnabled_ff, 1'b0, boostTargetVolts};
			end else begin
				prdata_ff <= 32'h00000000;
			end
		end
	end

	// register writes
	always_ff @(posedge clk) begin
		if (srst) begin
			boostSync_ff <= `BNV_RST_BOOST_SYNC;
		end else if (wrLane0 && regHit(paddr, `BNV_IDX_BOOST_SYNC)) begin
			boostSync_ff <= pwdata[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			divHigh_ff <= `BNV_RST_DIV_HIGH;
		end else if (wrLane0 && regHit(paddr, `BNV_IDX_DIV_HIGH)) begin
			divHigh_ff <= pwdata[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			divLow_ff <= `BNV_RST_DIV_LOW;
		end else if (wrLane0 && regHit(paddr, `BNV_IDX_DIV_LOW)) begin
			divLow_ff <= pwdata[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_ff <= `BNV_RST_CTRL;
		end else if (wrLane0 && regHit(paddr, `BNV_IDX_CTRL)) begin
			ctrl_ff <= pwdata[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			codeLoad_ff <= 1'b0;
		end else begin
			codeLoad_ff <= wrLane0 && regHit(paddr, `BNV_IDX_BOOST_SYNC);
		end
	end

	// pin synchronisers
	always_ff @(posedge clk) begin
		if (srst) begin
			frameSync_ff <= 3'h0;
			headLow_ff <= 2'h0;
			headHigh_ff <= 2'h0;
		end else begin
			frameSync_ff <= {frameSync_ff[1:0], frameSyncPin};
			headLow_ff <= {headLow_ff[0], headroomLowPin};
			headHigh_ff <= {headHigh_ff[0], headroomHighPin};
		end
	end

	// sync gating and pll counter
	always_ff @(posedge clk) begin
		if (srst) begin
			syncEnabled_ff <= 1'b0;
			pllRefPulse_ff <= 1'b0;
		end else begin
			syncEnabled_ff <= boostSync_ff.syncEn;
			pllRefPulse_ff <= boostSync_ff.syncEn && frameSync_ff[1] && !frameSync_ff[2];
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			pllCount_ff <= 13'h0000;
		end else if (boostSync_ff.syncEn) begin
			pllCount_ff <= pllAssembled;
		end else begin
			pllCount_ff <= 13'h0000;
		end
	end

	// field decode
	always_ff @(posedge clk) begin
		if (srst) begin
			ditherBits_ff <= 2'h0;
			rateFromResistor_ff <= 1'b0;
			outputRateCode_ff <= 5'h00;
			boostAdaptive_ff <= 1'b0;
		end else begin
			ditherBits_ff <= boostSync_ff.ditherDepth;
			rateFromResistor_ff <= divLow_ff.rateResistorEnable;
			outputRateCode_ff <= ctrl_ff.outputRateCode;
			boostAdaptive_ff <= ctrl_ff.adaptEn;
		end
	end

	bnv_boost_target u_boost (
		.clk(clk),
		.srst(srst),
		.boostVoltageCode(boostSync_ff.boostVoltageCode),
		.codeLoad(codeLoad_ff),
		.adaptEn(ctrl_ff.adaptEn),
		.stepUp(headLow_ff[1]),
		.stepDown(headHigh_ff[1]),
		.targetVolts(boostTargetVolts)
	);

	bnv_hyst_filter u_hyst (
		.clk(clk),
		.srst(srst),
		.dutyIn(dutyIn),
		.dutyInValid(dutyInValid),
		.hystCode(divLow_ff.hystCode),
		.dutyOut(dutyOut),
		.dutyOutValid(dutyOutValid)
	);

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign syncEnabled = syncEnabled_ff;
	assign pllRefPulse = pllRefPulse_ff;
	assign pllCount = pllCount_ff;
	assign ditherBits = ditherBits_ff;
	assign boostAdaptive = boostAdaptive_ff;
	assign rateFromResistor = rateFromResistor_ff;
	assign outputRateCode = outputRateCode_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	a_sync_ignored: assert property (!boostSync_ff.syncEn |=> !pllRefPulse)
		else $error("frame sync edge passed while disabled");
	a_sync_edge: assert property (boostSync_ff.syncEn && frameSync_ff[1] && !frameSync_ff[2] |=> pllRefPulse)
		else $error("frame sync edge lost while enabled");
	a_dither_depth: assert property (##1 ditherBits == $past(boostSync_ff.ditherDepth))
		else $error("dither depth decode wrong");
	a_pll_applied: assert property (boostSync_ff.syncEn |=> pllCount == $past({divHigh_ff, divLow_ff[7:3]}))
		else $error("pll count not assembled from both registers");
	a_pll_unused: assert property (!boostSync_ff.syncEn |=> pllCount == 13'h0000)
		else $error("pll count applied while sync disabled");
	a_rate_source: assert property (##1 rateFromResistor == $past(divLow_ff[2]))
		else $error("rate source select wrong");
	a_write_lands: assert property (wrLane0 && regHit(paddr, 8'hA6) |=> divHigh_ff == $past(pwdata[7:0]))
		else $error("write to divider high lost");
	a_low_lands: assert property (wrLane0 && regHit(paddr, 8'hA7) |=> divLow_ff == $past(pwdata[7:0]))
		else $error("write to divider low lost");
	a_readback_cfg: assert property (apbSetup && !pwrite && regHit(paddr, 8'hA5)
		|=> pready && prdata[7:0] == $past(boostSync_ff) && prdata[31:8] == 24'h000000)
		else $error("boost sync register read back wrong");
	a_apb_wait: assert property (apbSetup |=> pready ##1 !pready)
		else $error("apb answer not one wait state");
	a_sync_flag: assert property (##1 syncEnabled == $past(boostSync_ff.syncEn))
		else $error("sync enable flag wrong");
	a_adapt_flag: assert property (##1 boostAdaptive == $past(ctrl_ff.adaptEn))
		else $error("adaptive flag wrong");
	a_rate_code: assert property (##1 outputRateCode == $past(ctrl_ff.outputRateCode))
		else $error("output rate code wrong");
	a_unmapped_err: assert property (apbSetup && !mapped(paddr) |=> pready && pslverr)
		else $error("unmapped access not flagged");
	a_mapped_ok: assert property (apbSetup && mapped(paddr) |=> pready && !pslverr)
		else $error("mapped access flagged as error");
	a_strobe_off: assert property (apbDone && pwrite && !pstrb[0]
		|=> $stable(boostSync_ff) && $stable(divHigh_ff) && $stable(divLow_ff))
		else $error("write without lane strobe changed a register");
	a_cfg_lands: assert property (wrLane0 && regHit(paddr, `BNV_IDX_BOOST_SYNC)
		|=> boostSync_ff == $past(pwdata[7:0]))
		else $error("write to boost sync lost");
	a_read_high: assert property (apbSetup && !pwrite && regHit(paddr, `BNV_IDX_DIV_HIGH)
		|=> prdata == {24'h000000, $past(divHigh_ff)})
		else $error("divider high read back wrong");
	a_read_low: assert property (apbSetup && !pwrite && regHit(paddr, `BNV_IDX_DIV_LOW)
		|=> prdata == {24'h000000, $past(divLow_ff)})
		else $error("divider low read back wrong");

	c_sync_pulse: cover property (pllRefPulse);
	c_cfg_write: cover property (wrLane0 && regHit(paddr, 8'hA5));
	c_unmapped: cover property (pready && pslverr);
	c_adaptive: cover property (boostAdaptive && syncEnabled);
	c_strobe_off: cover property (apbDone && pwrite && !pstrb[0]);
endmodule : bnv_config_regs

// file: tb_bnv_config_regs.sv
// self-checking testbench for the backlight configuration registers
module tb_bnv_config_regs;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] ADDR_BSD = 12'h294;
	localparam logic [11:0] ADDR_DHI = 12'h298;
	localparam logic [11:0] ADDR_DLO = 12'h29C;
	localparam logic [11:0] ADDR_CTL = 12'h2A0;
	localparam logic [11:0] ADDR_STA = 12'h2A4;
	logic clk, srst, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdVal;
	logic [3:0] pstrb;
	logic frameSyncPin, headroomLowPin, headroomHighPin, dutyInValid, errVal, vldSeen;
	logic syncEnabled, pllRefPulse, boostAdaptive, rateFromResistor, dutyOutValid;
	logic [12:0] dutyIn, pllCount, dutyOut;
	logic [1:0] ditherBits;
	logic [5:0] boostTargetVolts;
	logic [4:0] outputRateCode;
	logic [11:0] regAddr [3] = '{ADDR_BSD, ADDR_DHI, ADDR_DLO};
	logic [7:0] pattern [3] = '{8'hFF, 8'h5A, 8'hA5};
	int hystW [4] = '{0, 4, 8, 32};
	int errorCnt, checked, base;
	bnv_config_regs bnv_config_regs_inst (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .frameSyncPin(frameSyncPin), .headroomLowPin(headroomLowPin),
		.headroomHighPin(headroomHighPin), .dutyIn(dutyIn), .dutyInValid(dutyInValid),
		.syncEnabled(syncEnabled), .pllRefPulse(pllRefPulse), .pllCount(pllCount), .ditherBits(ditherBits),
		.boostTargetVolts(boostTargetVolts), .boostAdaptive(boostAdaptive), .rateFromResistor(rateFromResistor),
		.outputRateCode(outputRateCode), .dutyOut(dutyOut), .dutyOutValid(dutyOutValid));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task printVerdict();
		$display("errors %0d, checks %0d", errorCnt, checked);
		if (errorCnt == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : printVerdict
	task checkVal(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errorCnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : checkVal
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			errorCnt++;
			printVerdict();
		end
		rdVal = prdata;
		errVal = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wrReg(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'hFFFFFF, d}, 4'hF);
		checkVal(32'(errVal), 32'h0);
	endtask : wrReg
	task rdChk(input logic [11:0] a, input logic [7:0] exp);
		apb(1'b0, a, 32'h0, 4'hF);
		checkVal(rdVal, {24'h0, exp});
		checkVal(32'(errVal), 32'h0);
	endtask : rdChk
	task settle();
		repeat (2) @(posedge clk);
		#1;
	endtask : settle
	task syncPulses(input int exp);
		int cnt;
		cnt = 0;
		@(posedge clk);
		frameSyncPin <= 1'b1;
		repeat (8) begin
			@(posedge clk);
			#1;
			cnt += int'(pllRefPulse === 1'b1);
		end
		frameSyncPin <= 1'b0;
		repeat (8) @(posedge clk);
		checkVal(32'(cnt), 32'(exp));
	endtask : syncPulses
	task duty(input int d);
		@(posedge clk);
		dutyIn <= 13'(d);
		dutyInValid <= 1'b1;
		@(posedge clk);
		dutyInValid <= 1'b0;
		#1;
		vldSeen = dutyOutValid;
		repeat (2) @(posedge clk);
		#1;
	endtask : duty
	task holdPin(input logic low, input logic high, input int cycles);
		@(posedge clk);
		headroomLowPin <= low;
		headroomHighPin <= high;
		repeat (cycles) @(posedge clk);
		headroomLowPin <= 1'b0;
		headroomHighPin <= 1'b0;
		settle();
	endtask : holdPin
	initial begin
		srst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		{frameSyncPin, headroomLowPin, headroomHighPin, dutyIn, dutyInValid} = '0;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		#1;
		checkVal(32'(boostTargetVolts), 32'h0A);
		checkVal(32'(pllCount), 32'h0);
		for (int i = 0; i < 3; i++) begin
			rdChk(regAddr[i], 8'h00);
			for (int p = 0; p < 3; p++) begin
				wrReg(regAddr[i], pattern[p]);
				rdChk(regAddr[i], pattern[p]);
			end
		end
		wrReg(ADDR_CTL, 8'h00);
		for (int c = 0; c < 32; c++) begin
			wrReg(ADDR_BSD, {1'b0, 2'(c), 5'(c)});
			settle();
			checkVal(32'(boostTargetVolts), (c >= 30) ? 32'h28 : 32'(c + 10));
			checkVal(32'(ditherBits), 32'(c % 4));
		end
		wrReg(ADDR_DHI, 8'h64);
		wrReg(ADDR_DLO, 8'h2F);
		settle();
		checkVal(32'(pllCount), 32'h0);
		checkVal(32'(rateFromResistor), 32'h1);
		wrReg(ADDR_BSD, 8'h80);
		settle();
		checkVal(32'(pllCount), 32'hC85);
		checkVal(32'(syncEnabled), 32'h1);
		syncPulses(1);
		wrReg(ADDR_BSD, 8'h00);
		settle();
		checkVal(32'(pllCount), 32'h0);
		syncPulses(0);
		wrReg(ADDR_DLO, 8'h00);
		wrReg(ADDR_CTL, 8'h13);
		settle();
		checkVal(32'(rateFromResistor), 32'h0);
		checkVal(32'(outputRateCode), 32'h13);
		apb(1'b1, 12'h300, 32'h000000FF, 4'hF);
		checkVal(32'(errVal), 32'h1);
		apb(0, 12'h300, 32'h0, 4'hF);
		checkVal({rdVal[30:0], errVal}, 32'h1);
		apb(1'b1, ADDR_DHI, 32'h000000FF, 4'h0);
		rdChk(ADDR_DHI, 8'h64);
		rdChk(ADDR_STA, 8'h0A);
		wrReg(ADDR_BSD, 8'h05);
		wrReg(ADDR_CTL, 8'h20);
		settle();
		checkVal({31'h0, boostAdaptive}, 32'h1);
		checkVal(32'(boostTargetVolts), 32'h0F);
		holdPin(1'b1, 1'b0, 40);
		checkVal(32'(boostTargetVolts), 32'h28);
		holdPin(1'b0, 1'b1, 40);
		checkVal(32'(boostTargetVolts), 32'h0A);
		wrReg(ADDR_BSD, 8'h07);
		settle();
		checkVal(32'(boostTargetVolts), 32'h11);
		wrReg(ADDR_CTL, 8'h00);
		holdPin(1'b1, 1'b0, 10);
		checkVal(32'(boostTargetVolts), 32'h11);
		wrReg(ADDR_DLO, 8'h00);
		base = 32'h400;
		duty(base);
		checkVal(32'(dutyOut), 32'(base));
		checkVal(32'(vldSeen), 32'h1);
		for (int c = 1; c < 4; c++) begin
			wrReg(ADDR_DLO, 8'(c));
			duty(base + hystW[c]);
			checkVal(32'(dutyOut), 32'(base));
			checkVal(32'(vldSeen), 32'h0);
			base += hystW[c] + 1;
			duty(base);
			checkVal(32'(dutyOut), 32'(base));
			checkVal(32'(vldSeen), 32'h1);
		end
		wrReg(ADDR_DLO, 8'h00);
		duty(base + 1);
		checkVal(32'(dutyOut), 32'(base + 1));
		checkVal(32'(vldSeen), 32'h1);
		printVerdict();
	end
endmodule : tb_bnv_config_regs
